// ---- ppr_params.svh ----
// Register offsets, field positions, reset values and the list of behaviour notes
// Notes on behaviour
// - Service select 0X: transfer-request pin is plain port C bit 4, no requests.
// - Select 10: pulse on line-1 transfers, line 1 no interrupt, needs port A enable.
// - Select 11: pulse on line-3 transfers, line 3 no interrupt, needs port B enable.
// - Pin select 00 both pins port C; 01 request pin autovectored, ack stays port C.
// - Pin select 10 only ack pin functional; 11 both pins functional, vectored.
// - Priority field orders the four handshake flags per fixed eight-entry table.
// - Port A direction bit: 0 input, 1 output; ignored in port mode 3.
// - Reset clears port A direction, all port A pins become inputs.
// - Port B direction works like port A but ignored in modes 2 and 3.
// - Port C direction sets port-C-function pins, mode independent, cleared on reset.
// - Vector register keeps upper six bits, low two written as zero, reads 0F after reset.
// - Reading vector register has no side effect and no priority evaluation.
// - Port A and B data always accessible, may advance handshake, keep through reset.
// - Port C read gives pin or latch by direction; buffer only for port C outputs.
// - Port C latch survives reset and behaves the same in every mode.
// - Alternate locations read live pins; writes acknowledged, data dropped.
// - Status bits 7-4 live handshake levels, bits 3-0 the four flags.
// - Timer control fields: 7-5 pin function, 4 zero-detect, 3 zero, 2-1 clock, 0 enable.
// - Port mode 00 uni 8, 01 uni 16, 10 bidir 8, 11 bidir 16.
// - Unused register bits read zero, except vector bits 1-0 until the first write; writes to them are dropped.
// - Zero-detect 0 reloads from preload after zero, 1 rolls over.
`ifndef PPR_PARAMS_SVH
`define PPR_PARAMS_SVH
`define PPR_OFS_GLOBAL      5'h00
`define PPR_OFS_SERVICE     5'h01
`define PPR_OFS_A_DIR       5'h02
`define PPR_OFS_B_DIR       5'h03
`define PPR_OFS_C_DIR       5'h04
`define PPR_OFS_VECTOR      5'h05
`define PPR_OFS_A_CTRL      5'h06
`define PPR_OFS_B_CTRL      5'h07
`define PPR_OFS_A_DATA      5'h08
`define PPR_OFS_B_DATA      5'h09
`define PPR_OFS_A_PINS      5'h0A
`define PPR_OFS_B_PINS      5'h0B
`define PPR_OFS_C_DATA      5'h0C
`define PPR_OFS_STATUS      5'h0D
`define PPR_OFS_TIMER_CTRL  5'h10
`define PPR_VECTOR_RESET    8'h0F
`define PPR_VECTOR_MASK     8'hFC
`define PPR_SERVICE_MASK    8'h7F
`define PPR_TIMER_MASK      8'hF7
`define PPR_BIT_SVC_EN      1
`define PPR_BIT_XFER_REQ    4
`define PPR_BIT_IRQ         5
`define PPR_BIT_IRQ_ACK     6
`define PPR_ACK_DELAY       2'h1
`endif

// ---- ppr_pkg.sv ----
// Types shared by the parallel port register bank
package ppr_pkg;
    typedef enum logic [1:0] {PPR_UNI8, PPR_UNI16, PPR_BIDIR8, PPR_BIDIR16} ppr_mode_t;

    typedef struct packed {
        logic       sel;
        logic       wr;
        logic [4:0] addr;
        logic [7:0] wdata;
    } ppr_bus_req_t;

    typedef struct packed {
        logic       ack;
        logic [7:0] rdata;
    } ppr_bus_rsp_t;

    typedef struct packed {
        logic [1:0] svc_sel;
        logic [1:0] pin_sel;
        logic [2:0] prio;
    } ppr_service_t;

    typedef struct packed {
        logic [2:0] pin_fn;
        logic       zd_ctrl;
        logic [1:0] clk_sel;
        logic       enable;
    } ppr_timer_ctrl_t;
endpackage : ppr_pkg

// ---- ppr_register_bank.sv ----
// Port section register bank with pin steering and interrupt priority
`timescale 1ns/10ps
`include "ppr_params.svh"
module ppr_register_bank (
    // Clock and reset
    input  wire logic                      ref_clk,
    input  wire logic                      rst_b,
    // Host bus
    input  wire ppr_pkg::ppr_bus_req_t     bus_req,
    output ppr_pkg::ppr_bus_rsp_t          bus_rsp,
    // Port A and B pins
    input  wire logic [7:0]                port_a_in,
    output logic [7:0]                     port_a_out,
    output logic [7:0]                     port_a_oe_b,
    input  wire logic [7:0]                port_b_in,
    output logic [7:0]                     port_b_out,
    output logic [7:0]                     port_b_oe_b,
    // Port C pins with alternate functions
    input  wire logic [7:0]                port_c_in,
    output logic [7:0]                     port_c_out,
    output logic [7:0]                     port_c_oe_b,
    // Alternate-function sources from the handshake and timer logic
    input  wire logic                      xfer_pulse_1,
    input  wire logic                      xfer_pulse_3,
    input  wire logic [3:0]                hsk_flag_set,
    input  wire logic [3:0]                hsk_flag_clr,
    input  wire logic [3:0]                hsk_line,
    input  wire logic [3:0]                hsk_flag_irq_en,
    input  wire logic [7:0]                alt_fn_out,
    input  wire logic [7:0]                alt_fn_oe_b,
    // Status toward the rest of the device
    output logic                           port_irq_request,
    output logic [1:0]                     port_irq_source,
    output logic                           port_irq_vectored,
    output logic                           port_irq_ack_active,
    output logic                           a_data_access,
    output logic                           b_data_access,
    output ppr_pkg::ppr_mode_t             port_mode,
    output ppr_pkg::ppr_timer_ctrl_t       timer_ctrl,
    output logic [7:0]                     port_a_data,
    output logic [7:0]                     port_b_data
);
    logic [7:0]                port_global_ctrl;
    ppr_pkg::ppr_service_t     port_service_ctrl;
    logic [7:0]                port_a_direction;
    logic [7:0]                port_b_direction;
    logic [7:0]                port_c_direction;
    logic [7:0]                port_vector_base;
    logic [7:0]                port_a_control;
    logic [7:0]                port_b_control;
    logic [7:0]                port_c_data;
    logic [3:0]                hsk_flag;
    logic [1:0]                ack_cnt;
    logic                      busy;
    logic [7:0]                next_rdata;
    logic [7:0]                c_is_alt;
    logic [7:0]                c_read;
    logic [3:0]                irq_pending;
    logic [1:0]                prio_order [4];
    logic                      wr_now;
    logic                      rd_now;
    logic [7:0]                rdata_q;

    // One access is taken per select; ack after a fixed delay
    assign wr_now = bus_req.sel && bus_req.wr && !busy;
    assign rd_now = bus_req.sel && !bus_req.wr && !busy;

    always_ff @(posedge ref_clk)
    begin
        if (!rst_b)
        begin
            busy    <= 1'b0;
            ack_cnt <= 2'h0;
        end
        else if (bus_req.sel && !busy)
        begin
            busy    <= 1'b1;
            ack_cnt <= `PPR_ACK_DELAY;
        end
        else if (busy && ack_cnt != 2'h0)
            ack_cnt <= ack_cnt - 2'h1;
        else if (busy && !bus_req.sel)
            busy <= 1'b0;
    end

    // One driver for the whole response keeps ack and read data apart cleanly
    assign bus_rsp = {busy && ack_cnt == 2'h0 && bus_req.sel, rdata_q};

    // Control registers cleared by reset, except the vector register, which loads 0F
    always_ff @(posedge ref_clk)
    begin
        if (!rst_b)
        begin
            port_global_ctrl  <= 8'h00;
            port_service_ctrl <= '0;
            port_a_direction  <= 8'h00;
            port_b_direction  <= 8'h00;
            port_c_direction  <= 8'h00;
            port_vector_base  <= `PPR_VECTOR_RESET;
            port_a_control    <= 8'h00;
            port_b_control    <= 8'h00;
            timer_ctrl        <= '0;
        end
        else if (wr_now)
        begin
            case (bus_req.addr)
                `PPR_OFS_GLOBAL:     port_global_ctrl  <= bus_req.wdata;
                `PPR_OFS_SERVICE:    port_service_ctrl <= bus_req.wdata[6:0];
                `PPR_OFS_A_DIR:      port_a_direction  <= bus_req.wdata;
                `PPR_OFS_B_DIR:      port_b_direction  <= bus_req.wdata;
                `PPR_OFS_C_DIR:      port_c_direction  <= bus_req.wdata;
                `PPR_OFS_VECTOR:     port_vector_base  <= bus_req.wdata & `PPR_VECTOR_MASK;
                `PPR_OFS_A_CTRL:     port_a_control    <= bus_req.wdata;
                `PPR_OFS_B_CTRL:     port_b_control    <= bus_req.wdata;
                `PPR_OFS_TIMER_CTRL: timer_ctrl        <= {bus_req.wdata[7:4], bus_req.wdata[2:0]};
                default:             ;
            endcase
        end
    end

    // Data latches have no reset so contents survive it
    always_ff @(posedge ref_clk)
    begin
        if (wr_now && bus_req.addr == `PPR_OFS_A_DATA)
            port_a_data <= bus_req.wdata;
        if (wr_now && bus_req.addr == `PPR_OFS_B_DATA)
            port_b_data <= bus_req.wdata;
        if (wr_now && bus_req.addr == `PPR_OFS_C_DATA)
            port_c_data <= bus_req.wdata;
    end

    // Handshake flags; a set in the same cycle as a clear wins
    always_ff @(posedge ref_clk)
    begin
        if (!rst_b)
            hsk_flag <= 4'h0;
        else
            hsk_flag <= (hsk_flag & ~hsk_flag_clr) | hsk_flag_set;
    end

    // Data register accesses reported so the handshake logic can advance
    assign a_data_access = (wr_now || rd_now) && bus_req.addr == `PPR_OFS_A_DATA;
    assign b_data_access = (wr_now || rd_now) && bus_req.addr == `PPR_OFS_B_DATA;

    assign port_mode = ppr_pkg::ppr_mode_t'(port_global_ctrl[7:6]);

    // Ports A and B: mode 3 hands both directions to the handshake logic, mode 2 only port B
    always_comb
    begin
        port_a_out  = port_a_data;
        port_b_out  = port_b_data;
        port_a_oe_b = ~port_a_direction;
        port_b_oe_b = ~port_b_direction;
        if (port_mode == ppr_pkg::PPR_BIDIR16)
            port_a_oe_b = 8'hFF;
        if (port_mode == ppr_pkg::PPR_BIDIR8 || port_mode == ppr_pkg::PPR_BIDIR16)
            port_b_oe_b = 8'hFF;
    end

    // Which port C pins carry their alternate function
    always_comb
    begin
        c_is_alt = 8'h00;
        c_is_alt[`PPR_BIT_XFER_REQ] = port_service_ctrl.svc_sel[1];
        c_is_alt[`PPR_BIT_IRQ]      = port_service_ctrl.pin_sel[0];
        c_is_alt[`PPR_BIT_IRQ_ACK]  = port_service_ctrl.pin_sel[1];
        c_is_alt[3] = timer_ctrl.pin_fn[2:1] != 2'b00;
        c_is_alt[7] = timer_ctrl.pin_fn[2:1] == 2'b10;
        c_is_alt[2] = timer_ctrl.clk_sel != 2'b00;
    end

    // Interrupt requests; lines feeding the transfer pin leave the interrupt path
    always_comb
    begin
        irq_pending = hsk_flag & hsk_flag_irq_en;
        if (port_service_ctrl.svc_sel == 2'b10)
            irq_pending[0] = 1'b0;
        if (port_service_ctrl.svc_sel == 2'b11)
            irq_pending[2] = 1'b0;
    end

    // Priority order, highest first, as flag indices
    always_comb
    begin
        case (port_service_ctrl.prio)
            3'b000:  prio_order = '{2'd0, 2'd1, 2'd2, 2'd3};
            3'b001:  prio_order = '{2'd1, 2'd0, 2'd2, 2'd3};
            3'b010:  prio_order = '{2'd0, 2'd1, 2'd3, 2'd2};
            3'b011:  prio_order = '{2'd1, 2'd0, 2'd3, 2'd2};
            3'b100:  prio_order = '{2'd2, 2'd3, 2'd0, 2'd1};
            3'b101:  prio_order = '{2'd2, 2'd3, 2'd1, 2'd0};
            3'b110:  prio_order = '{2'd3, 2'd2, 2'd0, 2'd1};
            default: prio_order = '{2'd3, 2'd2, 2'd1, 2'd0};
        endcase
    end

    always_comb
    begin
        port_irq_source = 2'd0;
        for (int i = 3; i >= 0; i--)
            if (irq_pending[prio_order[i]])
                port_irq_source = prio_order[i];
    end

    assign port_irq_request    = port_service_ctrl.pin_sel[0] && irq_pending != 4'h0;
    assign port_irq_vectored   = port_service_ctrl.pin_sel == 2'b11;
    assign port_irq_ack_active = port_service_ctrl.pin_sel[1] && !port_c_in[`PPR_BIT_IRQ_ACK];

    // Port C pins: buffer only when port C function and direction out
    always_comb
    begin
        port_c_out  = port_c_data;
        port_c_oe_b = 8'hFF;
        for (int i = 0; i < 8; i++)
        begin
            if (c_is_alt[i])
            begin
                port_c_out[i]  = alt_fn_out[i];
                port_c_oe_b[i] = alt_fn_oe_b[i];
            end
            else
                port_c_oe_b[i] = ~port_c_direction[i];
        end
        if (c_is_alt[`PPR_BIT_XFER_REQ])
        begin
            // Pulses only when the matching service enable is set
            port_c_out[`PPR_BIT_XFER_REQ]  = port_service_ctrl.svc_sel[0]
                ? !(xfer_pulse_3 && port_b_control[`PPR_BIT_SVC_EN])
                : !(xfer_pulse_1 && port_a_control[`PPR_BIT_SVC_EN]);
            port_c_oe_b[`PPR_BIT_XFER_REQ] = 1'b0;
        end
        if (c_is_alt[`PPR_BIT_IRQ])
        begin
            // Open-drain request line, low when asserted
            port_c_out[`PPR_BIT_IRQ]  = 1'b0;
            port_c_oe_b[`PPR_BIT_IRQ] = !port_irq_request;
        end
    end

    // Port C read: pin when input, latch when output, either function
    assign c_read = (port_c_direction & port_c_data) | (~port_c_direction & port_c_in);

    // Read data; reads here have no side effect other than the port A and B data access pulses; the vector register has none
    always_comb
    begin
        case (bus_req.addr)
            `PPR_OFS_GLOBAL:     next_rdata = port_global_ctrl;
            `PPR_OFS_SERVICE:    next_rdata = {1'b0, port_service_ctrl};
            `PPR_OFS_A_DIR:      next_rdata = port_a_direction;
            `PPR_OFS_B_DIR:      next_rdata = port_b_direction;
            `PPR_OFS_C_DIR:      next_rdata = port_c_direction;
            `PPR_OFS_VECTOR:     next_rdata = port_vector_base;
            `PPR_OFS_A_CTRL:     next_rdata = port_a_control;
            `PPR_OFS_B_CTRL:     next_rdata = port_b_control;
            `PPR_OFS_A_DATA:     next_rdata = port_a_data;
            `PPR_OFS_B_DATA:     next_rdata = port_b_data;
            `PPR_OFS_A_PINS:     next_rdata = port_a_in;
            `PPR_OFS_B_PINS:     next_rdata = port_b_in;
            `PPR_OFS_C_DATA:     next_rdata = c_read;
            `PPR_OFS_STATUS:     next_rdata = {hsk_line[3:0], hsk_flag};
            `PPR_OFS_TIMER_CTRL: next_rdata = {timer_ctrl[6:3], 1'b0, timer_ctrl[2:0]};
            default:             next_rdata = 8'h00;
        endcase
    end

    // Read data captured at take so it stands through the acknowledge
    always_ff @(posedge ref_clk)
    begin
        if (!rst_b)
            rdata_q <= 8'h00;
        else if (rd_now)
            rdata_q <= next_rdata;
    end
endmodule : ppr_register_bank

// ---- ppr_bank_properties.sv ----
// Concurrent checks on the register bank ports
`timescale 1ns/10ps
`include "ppr_params.svh"
module ppr_bank_properties (
    // Clock and reset
    input wire logic                     ref_clk,
    input wire logic                     rst_b,
    // Host bus
    input wire ppr_pkg::ppr_bus_req_t    bus_req,
    input wire ppr_pkg::ppr_bus_rsp_t    bus_rsp,
    // Port and status outputs
    input wire logic [7:0]               port_a_out,
    input wire logic [7:0]               port_a_oe_b,
    input wire logic [7:0]               port_b_oe_b,
    input wire logic                     a_data_access,
    input wire ppr_pkg::ppr_mode_t       port_mode,
    input wire ppr_pkg::ppr_timer_ctrl_t timer_ctrl,
    input wire logic [7:0]               port_a_data
);
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_b);

    AST_ACK_TIMING: assert property ($rose(bus_req.sel) |-> !bus_rsp.ack [*2] ##1 bus_rsp.ack)
        else $error("ack not two cycles after take");
    AST_ACK_HOLD: assert property (bus_rsp.ack && bus_req.sel |=> bus_rsp.ack || !bus_req.sel)
        else $error("ack dropped while select high");
    AST_ACK_IDLE: assert property (!bus_req.sel |-> !bus_rsp.ack)
        else $error("ack without select");
    AST_A_DIR_MODE3: assert property (port_mode == ppr_pkg::PPR_BIDIR16 |-> port_a_oe_b == 8'hFF)
        else $error("port A direction used in mode 3");
    AST_B_DIR_MODE23: assert property (port_mode[1] |-> port_b_oe_b == 8'hFF)
        else $error("port B direction used in modes 2 or 3");
    // Reset itself is the cause here, so no disable
    AST_RESET_CLEAR: assert property (disable iff (1'b0) !rst_b |=> port_a_oe_b == 8'hFF && timer_ctrl == 7'h00)
        else $error("reset left direction or timer bits set");
    AST_UNUSED_ZERO: assert property (bus_rsp.ack && !bus_req.wr && bus_req.addr == `PPR_OFS_SERVICE
        |-> bus_rsp.rdata[7] == 1'b0)
        else $error("unused service bit read one");
    AST_TIMER_BIT3: assert property (bus_rsp.ack && !bus_req.wr && bus_req.addr == `PPR_OFS_TIMER_CTRL
        |-> bus_rsp.rdata[3] == 1'b0)
        else $error("unused timer bit read one");
    AST_A_ACCESS: assert property (a_data_access |-> bus_req.sel && bus_req.addr == `PPR_OFS_A_DATA ##1 !a_data_access)
        else $error("port A access pulse wrong");
    // Checked after a write only, since the latch has no reset value
    AST_A_OUT: assert property ($rose(bus_req.sel) && bus_req.wr && bus_req.addr == `PPR_OFS_A_DATA
        |=> port_a_out == $past(bus_req.wdata) && port_a_data == $past(bus_req.wdata))
        else $error("port A drive differs from written data");
endmodule : ppr_bank_properties

bind ppr_register_bank ppr_bank_properties u_ppr_bank_properties (.ref_clk, .rst_b, .bus_req, .bus_rsp,
    .port_a_out, .port_a_oe_b, .port_b_oe_b, .a_data_access, .port_mode, .timer_ctrl, .port_a_data);

// ---- ppr_host_model.sv ----
// Host bus master model facing the register bank
`timescale 1ns/10ps
module ppr_host_model (
    // Clock
    input wire logic                  ref_clk,
    // Bus
    output ppr_pkg::ppr_bus_req_t     bus_req,
    input wire ppr_pkg::ppr_bus_rsp_t bus_rsp,
    // Status
    output logic                      timed_out
);
    initial
    begin
        bus_req   = '0;
        timed_out = 1'b0;
    end

    // Hold request until ack is seen at an edge, then idle a cycle
    task access(input logic wr, input logic [4:0] addr, input logic [7:0] wdata, output logic [7:0] rdata);
        int   n;
        logic got;
        @(posedge ref_clk);
        #1 bus_req = {1'b1, wr, addr, wdata};
        n = 0;
        // Sampled at the rising edge, before that edge's updates land
        do
        begin
            @(posedge ref_clk);
            got   = bus_rsp.ack;
            rdata = bus_rsp.rdata;
            n++;
        end
        while (got !== 1'b1 && n < 20);
        // Released lines show garbage, not the old value
        #1 bus_req = {1'b0, ~wr, ~addr, ~wdata};
        timed_out = timed_out | (got !== 1'b1);
    endtask : access
endmodule : ppr_host_model

// ---- testbench.sv ----
// Self-checking bench for the register bank
`timescale 1ns/10ps
`include "ppr_params.svh"
module testbench;
    logic                     ref_clk, rst_b, xfer_pulse_1, xfer_pulse_3, irq_req, irq_vec, irq_ack, a_acc, b_acc, tmo;
    ppr_pkg::ppr_bus_req_t    bus_req;
    ppr_pkg::ppr_bus_rsp_t    bus_rsp;
    logic [7:0]               a_in, b_in, c_in, a_out, a_oe_b, b_out, b_oe_b, c_out, c_oe_b, alt_out, alt_oe_b, a_d, b_d;
    logic [3:0]               f_set, f_clr, h_line, f_en;
    logic [1:0]               irq_src;
    ppr_pkg::ppr_mode_t       mode;
    ppr_pkg::ppr_timer_ctrl_t tctl;
    int                       bad_count, n_checks;
    logic [4:0]               ra [5] = '{`PPR_OFS_SERVICE, `PPR_OFS_A_DIR, `PPR_OFS_B_DIR, `PPR_OFS_C_DIR,
                                         `PPR_OFS_TIMER_CTRL};
    logic [7:0]               rm [5] = '{8'h7F, 8'hFF, 8'hFF, 8'hFF, 8'hF7};
    logic [1:0]               top [8] = '{2'h0, 2'h1, 2'h0, 2'h1, 2'h2, 2'h2, 2'h3, 2'h3};

    ppr_register_bank u_ppr_register_bank (.ref_clk, .rst_b, .bus_req, .bus_rsp, .port_a_in(a_in),
        .port_a_out(a_out), .port_a_oe_b(a_oe_b), .port_b_in(b_in), .port_b_out(b_out), .port_b_oe_b(b_oe_b),
        .port_c_in(c_in), .port_c_out(c_out), .port_c_oe_b(c_oe_b), .xfer_pulse_1, .xfer_pulse_3,
        .hsk_flag_set(f_set), .hsk_flag_clr(f_clr), .hsk_line(h_line), .hsk_flag_irq_en(f_en),
        .alt_fn_out(alt_out), .alt_fn_oe_b(alt_oe_b), .port_irq_request(irq_req), .port_irq_source(irq_src),
        .port_irq_vectored(irq_vec), .port_irq_ack_active(irq_ack), .a_data_access(a_acc),
        .b_data_access(b_acc), .port_mode(mode), .timer_ctrl(tctl), .port_a_data(a_d), .port_b_data(b_d));
    ppr_host_model u_ppr_host_model (.ref_clk, .bus_req, .bus_rsp, .timed_out(tmo));

    initial
    begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end

    task check(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            bad_count++;
            $display("BAD t=%0t got %h expected %h", $time, got, exp);
        end
    endtask : check
    task wr(input logic [4:0] a, input logic [7:0] d);
        logic [7:0] x;
        u_ppr_host_model.access(1'b1, a, d, x);
        if (tmo === 1'b1)
            stop_test();
    endtask : wr
    task rd(input logic [4:0] a, input logic [7:0] e);
        logic [7:0] x;
        u_ppr_host_model.access(1'b0, a, 8'h00, x);
        check(x, e);
        if (tmo === 1'b1)
            stop_test();
    endtask : rd
    task reset_for(input int n);
        rst_b = 1'b0;
        repeat (n) @(posedge ref_clk);
        #1 rst_b = 1'b1;
    endtask : reset_for
    task stop_test;
        if (tmo !== 1'b0)
            bad_count++;
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : stop_test

    // Hang guard well above the sequence length
    initial
    begin
        #200000;
        bad_count++;
        stop_test();
    end

    initial
    begin
        {xfer_pulse_1, xfer_pulse_3, f_set, f_clr, h_line, f_en, alt_out, alt_oe_b} = '0;
        {a_in, b_in, c_in, bad_count, n_checks} = '0;
        reset_for(16);
        rd(`PPR_OFS_VECTOR, 8'h0F);
        rd(`PPR_OFS_VECTOR, 8'h0F);
        wr(`PPR_OFS_VECTOR, 8'hFF);
        rd(`PPR_OFS_VECTOR, 8'hFC);
        rd(5'h0E, 8'h00);
        for (int i = 0; i < 5; i++)
        begin
            rd(ra[i], 8'h00);
            wr(ra[i], 8'hFF);
            rd(ra[i], rm[i]);
            wr(ra[i], 8'h00);
        end
        wr(`PPR_OFS_A_DIR, 8'h0F);
        wr(`PPR_OFS_B_DIR, 8'h3C);
        check(a_oe_b, 8'hF0);
        check(b_oe_b, 8'hC3);
        wr(`PPR_OFS_GLOBAL, 8'h80);
        check({6'h00, mode}, 8'h02);
        check(a_oe_b, 8'hF0);
        check(b_oe_b, 8'hFF);
        wr(`PPR_OFS_GLOBAL, 8'hC0);
        check(a_oe_b, 8'hFF);
        wr(`PPR_OFS_GLOBAL, 8'h00);
        wr(`PPR_OFS_A_DATA, 8'h5A);
        wr(`PPR_OFS_C_DIR, 8'h0F);
        wr(`PPR_OFS_C_DATA, 8'hA5);
        wr(`PPR_OFS_TIMER_CTRL, 8'hB5);
        check({1'b0, tctl}, 8'h5D);
        wr(`PPR_OFS_TIMER_CTRL, 8'h00);
        c_in = 8'h3C;
        rd(`PPR_OFS_C_DATA, 8'h35);
        check(c_oe_b, 8'hF0);
        reset_for(2);
        check(a_d, 8'h5A);
        check(a_out, 8'h5A);
        wr(`PPR_OFS_B_DATA, 8'hC3);
        check(b_d, 8'hC3);
        check(b_out, 8'hC3);
        check(a_oe_b, 8'hFF);
        rd(`PPR_OFS_C_DATA, 8'h3C);
        wr(`PPR_OFS_C_DIR, 8'hFF);
        rd(`PPR_OFS_C_DATA, 8'hA5);
        check(c_oe_b, 8'h00);
        check(c_out, 8'hA5);
        wr(`PPR_OFS_C_DIR, 8'h00);
        a_in = 8'h96;
        b_in = 8'h69;
        wr(`PPR_OFS_A_PINS, 8'h00);
        rd(`PPR_OFS_A_PINS, 8'h96);
        rd(`PPR_OFS_B_PINS, 8'h69);
        h_line = 4'hA;
        f_en   = 4'hF;
        #1 f_set = 4'hF;
        @(posedge ref_clk);
        #1 f_set = 4'h0;
        wr(`PPR_OFS_STATUS, 8'h00);
        rd(`PPR_OFS_STATUS, 8'hAF);
        for (int i = 0; i < 8; i++)
        begin
            wr(`PPR_OFS_SERVICE, 8'(i));
            check({6'h00, irq_src}, {6'h00, top[i]});
        end
        for (int i = 0; i < 4; i++)
        begin
            wr(`PPR_OFS_SERVICE, {3'b000, 2'(i), 3'b000});
            check({5'h00, c_oe_b[5], irq_vec, irq_ack}, {5'h00, ~i[0], i == 3, i[1]});
        end
        wr(`PPR_OFS_SERVICE, 8'h00);
        check({7'h00, c_oe_b[4]}, 8'h01);
        wr(`PPR_OFS_A_CTRL, 8'h02);
        wr(`PPR_OFS_B_CTRL, 8'h02);
        wr(`PPR_OFS_SERVICE, 8'h40);
        check({5'h00, c_oe_b[4], irq_src}, 8'h01);
        wr(`PPR_OFS_SERVICE, 8'h64);
        check({5'h00, c_oe_b[4], irq_src}, 8'h03);
        #1 xfer_pulse_3 = 1'b1;
        #1 check({7'h00, c_out[4]}, 8'h00);
        wr(`PPR_OFS_B_CTRL, 8'h00);
        check({7'h00, c_out[4]}, 8'h01);
        wr(`PPR_OFS_SERVICE, 8'h40);
        check({7'h00, c_out[4]}, 8'h01);
        #1 xfer_pulse_1 = 1'b1;
        #1 check({7'h00, c_out[4]}, 8'h00);
        wr(`PPR_OFS_A_CTRL, 8'h00);
        check({7'h00, c_out[4]}, 8'h01);
        stop_test();
    end
endmodule : testbench
